// ===== pkg/spc_defs.vh
// register offsets, field positions, reset values and masks of the serial port
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// register indices; byte address is four times the index
`define SPC_IDX_CTRL1   3'h0
`define SPC_IDX_CTRL2   3'h1
`define SPC_IDX_DIV     3'h2
`define SPC_IDX_STATUS  3'h3
`define SPC_IDX_DATA    3'h5

// control one fields
`define SPC_B_IE        7
`define SPC_B_EN        6
`define SPC_B_TIE       5
`define SPC_B_ROLE_SELECT      4
`define SPC_B_POL       3
`define SPC_B_PHA       2
`define SPC_B_SELECT_OUTPUT_ENABLE      1
`define SPC_B_LSBF      0

// control two fields
`define SPC_B_MFE       4
`define SPC_B_BIOE      3
`define SPC_B_SWAI      1
`define SPC_B_PIN       0

// divider select fields
`define SPC_F_PRE_HI    6
`define SPC_F_PRE_LO    4
`define SPC_F_RATE_HI   2
`define SPC_F_RATE_LO   0

// status fields
`define SPC_B_TC        7
`define SPC_B_TE        5
`define SPC_B_MF        4

// reset values and writable masks
`define SPC_RST_CTRL1   8'h04
`define SPC_RST_CTRL2   8'h00
`define SPC_RST_DIV     8'h00
`define SPC_MSK_CTRL2   8'h1b
`define SPC_MSK_DIV     8'h77

// edges in one byte transfer
`define SPC_EDGES       5'h10

`endif

// ===== logic/spc_core.v
// serial peripheral port: registers, master and slave engine, pin control
`timescale 1ns/10ps
`default_nettype none
`include "spc_defs.vh"

module spc_core (
  input  wire        clock,
  input  wire        reset_n,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        wait_mode,
  input  wire        stop_mode,
  input  wire        mosi_in,
  output reg         mosi_out,
  output reg         mosi_oe,
  input  wire        miso_in,
  output reg         miso_out,
  output reg         miso_oe,
  input  wire        sck_in,
  output reg         sck_out,
  output reg         sck_oe,
  input  wire        ss_in,
  output reg         ss_out,
  output reg         ss_oe,
  output reg         irq
);

  // ***************************************************************
  // helper functions
  // ***************************************************************

  // bit that leaves the shifter next
  function obit;
    input [7:0] sh;
    input       lsbf;
    begin
      obit = lsbf ? sh[0] : sh[7];
    end
  endfunction

  // shift one received bit in; data register keeps msb in bit 7
  function [7:0] shin;
    input [7:0] sh;
    input       b;
    input       lsbf;
    begin
      shin = lsbf ? {b, sh[7:1]} : {sh[6:0], b};
    end
  endfunction

  // ***************************************************************
  // registers and their fields
  // ***************************************************************

  reg  [7:0]  ctrl1_reg;
  reg  [7:0]  ctrl2_reg;
  reg  [7:0]  div_reg;
  reg  [7:0]  txb_reg;
  reg         txf_reg;
  reg  [7:0]  rx_reg;
  reg         tc_reg;
  reg         te_reg;
  reg         mf_reg;
  reg         tc_arm_reg;
  reg         te_arm_reg;
  reg         mf_arm_reg;

  wire        ie   = ctrl1_reg[`SPC_B_IE];
  wire        en   = ctrl1_reg[`SPC_B_EN];
  wire        tie  = ctrl1_reg[`SPC_B_TIE];
  wire        role_select = ctrl1_reg[`SPC_B_ROLE_SELECT];
  wire        pol  = ctrl1_reg[`SPC_B_POL];
  wire        pha  = ctrl1_reg[`SPC_B_PHA];
  wire        select_output_enable = ctrl1_reg[`SPC_B_SELECT_OUTPUT_ENABLE];
  wire        lsbf = ctrl1_reg[`SPC_B_LSBF];
  wire        mfe  = ctrl2_reg[`SPC_B_MFE];
  wire        bioe = ctrl2_reg[`SPC_B_BIOE];
  wire        swai = ctrl2_reg[`SPC_B_SWAI];
  wire        pin1 = ctrl2_reg[`SPC_B_PIN];
  wire [2:0]  pre  = div_reg[`SPC_F_PRE_HI:`SPC_F_PRE_LO];
  wire [2:0]  rate = div_reg[`SPC_F_RATE_HI:`SPC_F_RATE_LO];

  // ***************************************************************
  // pin input synchronisers
  // ***************************************************************

  reg  [2:0]  sck_s_reg;
  reg  [2:0]  ss_s_reg;
  reg  [2:0]  mosi_s_reg;
  reg  [2:0]  miso_s_reg;
  reg         sck_f_reg;
  reg         ss_f_reg;
  reg         mosi_f_reg;
  reg         miso_f_reg;
  reg         sck_d_reg;

  // a level counts only once stages two and three agree
  always @(posedge clock) begin
    if (!reset_n) begin
      sck_s_reg  <= 3'h0;
      ss_s_reg   <= 3'h7;
      mosi_s_reg <= 3'h0;
      miso_s_reg <= 3'h0;
      sck_f_reg  <= 1'b0;
      ss_f_reg   <= 1'b1;
      mosi_f_reg <= 1'b0;
      miso_f_reg <= 1'b0;
      sck_d_reg  <= 1'b0;
    end else begin
      sck_s_reg  <= {sck_s_reg[1:0], sck_in};
      ss_s_reg   <= {ss_s_reg[1:0], ss_in};
      mosi_s_reg <= {mosi_s_reg[1:0], mosi_in};
      miso_s_reg <= {miso_s_reg[1:0], miso_in};
      if (sck_s_reg[1] == sck_s_reg[2])
        sck_f_reg <= sck_s_reg[2];
      if (ss_s_reg[1] == ss_s_reg[2])
        ss_f_reg <= ss_s_reg[2];
      if (mosi_s_reg[1] == mosi_s_reg[2])
        mosi_f_reg <= mosi_s_reg[2];
      if (miso_s_reg[1] == miso_s_reg[2])
        miso_f_reg <= miso_s_reg[2];
      sck_d_reg  <= sck_f_reg;
    end
  end

  // ***************************************************************
  // avalon slave
  // ***************************************************************

  wire        req  = avs_read | avs_write;
  wire        acc  = req & ~avs_waitrequest;
  wire [2:0]  idx  = avs_address[4:2];
  wire        rd_a = acc & avs_read;
  wire        wr_a = acc & avs_write & avs_byteenable[0];
  wire [7:0]  wd   = avs_writedata[7:0];
  reg  [7:0]  rd_val;

  // read mux; reserved offsets fall through to zero
  always @* begin
    rd_val = 8'h00;
    if (idx == `SPC_IDX_CTRL1)
      rd_val = ctrl1_reg;
    else if (idx == `SPC_IDX_CTRL2)
      rd_val = ctrl2_reg & `SPC_MSK_CTRL2;
    else if (idx == `SPC_IDX_DIV)
      rd_val = div_reg & `SPC_MSK_DIV;
    else if (idx == `SPC_IDX_STATUS)
      rd_val = {tc_reg, 1'b0, te_reg, mf_reg, 4'h0};
    else if (idx == `SPC_IDX_DATA)
      rd_val = rx_reg;
    else
      rd_val = 8'h00;
  end

  // one wait cycle, then the answer edge; readdata settles before it
  always @(posedge clock) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (acc) begin
      avs_waitrequest <= 1'b1;
    end else if (req) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= {24'h00_0000, rd_val};
    end
  end

  // control writes; status and reserved writes change nothing
  always @(posedge clock) begin
    if (!reset_n) begin
      ctrl1_reg <= `SPC_RST_CTRL1;
      ctrl2_reg <= `SPC_RST_CTRL2;
      div_reg   <= `SPC_RST_DIV;
    end else if (wr_a) begin
      if (idx == `SPC_IDX_CTRL1)
        ctrl1_reg <= wd;
      else if (idx == `SPC_IDX_CTRL2)
        ctrl2_reg <= wd & `SPC_MSK_CTRL2;
      else if (idx == `SPC_IDX_DIV)
        div_reg <= wd & `SPC_MSK_DIV;
    end
  end

  // ***************************************************************
  // clock divider for the master
  // ***************************************************************

  // half period is divisor/2; slave cannot follow divisors 2 and 4
  wire [10:0] half = {7'h00, 1'b0, pre} + 11'h001;
  wire [10:0] hcnt = half << rate;
  wire [10:0] hlast = hcnt - 11'h001;
  reg  [10:0] cnt_reg;
  reg         busy_reg;
  reg  [4:0]  edge_reg;
  reg         lvl_reg;
  reg  [7:0]  sh_reg;
  reg         bit_reg;

  // wait with stop-in-wait or stop freezes master generation
  wire run_m = en & role_select & ~mf_reg & ~stop_mode
               & ~(wait_mode & swai);
  wire tick  = run_m & busy_reg & (cnt_reg == hlast);

  // ***************************************************************
  // shared shift engine
  // ***************************************************************

  // data input pin depends on role and pin mode
  wire din = role_select ? (pin1 ? mosi_f_reg : miso_f_reg)
                  : (pin1 ? miso_f_reg : mosi_f_reg);
  wire sedge = en & ~role_select & ~ss_f_reg
               & (sck_f_reg ^ sck_d_reg);
  wire medge = tick & (edge_reg != `SPC_EDGES);
  wire ev    = role_select ? medge : sedge;
  wire [4:0] e_num = edge_reg + 5'h01;
  // odd edges sample in phase zero, even edges in phase one
  wire samp  = pha ? ~e_num[0] : e_num[0];
  wire [7:0] sh_nx = shin(sh_reg, samp ? din : bit_reg, lsbf);
  wire last  = ev & (e_num == `SPC_EDGES);
  wire mfault = en & role_select & mfe & ~select_output_enable & ~ss_f_reg;
  wire m_load = run_m & ~busy_reg & txf_reg;
  wire s_load = en & ~role_select & (edge_reg == 5'h00) & txf_reg
                & ~sedge;
  wire load  = m_load | s_load;
  wire d_wr  = wr_a & (idx == `SPC_IDX_DATA);
  wire d_ok  = d_wr & te_reg & te_arm_reg;

  // transfer sequencing for both roles
  always @(posedge clock) begin
    if (!reset_n) begin
      busy_reg <= 1'b0;
      edge_reg <= 5'h00;
      lvl_reg  <= 1'b0;
      cnt_reg  <= 11'h000;
      sh_reg   <= 8'h00;
      bit_reg  <= 1'b0;
    end else if (!en || (role_select && mf_reg)) begin
      busy_reg <= 1'b0;
      edge_reg <= 5'h00;
      lvl_reg  <= 1'b0;
      cnt_reg  <= 11'h000;
    end else if (!role_select && ss_f_reg) begin
      edge_reg <= 5'h00; // deselect aborts a partial byte
      busy_reg <= 1'b0;
      if (s_load)
        sh_reg <= txb_reg;
    end else begin
      // divider runs only while the master is busy and not frozen
      if (run_m && busy_reg)
        cnt_reg <= (cnt_reg == hlast) ? 11'h000 : cnt_reg + 11'h001;
      if (load) begin
        sh_reg   <= txb_reg;
        busy_reg <= role_select;
        edge_reg <= 5'h00;
        lvl_reg  <= 1'b0;
        cnt_reg  <= pha ? hlast : 11'h000;
      end else if (ev) begin
        lvl_reg  <= ~lvl_reg;
        edge_reg <= last && !role_select ? 5'h00 : e_num;
        if (last)
          sh_reg <= sh_nx;
        else if (samp)
          bit_reg <= din;
        else if (e_num != 5'h01)
          sh_reg <= sh_nx;
      end else if (tick) begin
        busy_reg <= 1'b0; // trailing half period ends the byte
        edge_reg <= 5'h00;
      end
    end
  end

  // ***************************************************************
  // buffers and flags
  // ***************************************************************

  // set always wins over a clear in the same cycle
  always @(posedge clock) begin
    if (!reset_n) begin
      txb_reg    <= 8'h00;
      txf_reg    <= 1'b0;
      rx_reg     <= 8'h00;
      tc_reg     <= 1'b0;
      te_reg     <= 1'b1;
      mf_reg     <= 1'b0;
      tc_arm_reg <= 1'b0;
      te_arm_reg <= 1'b0;
      mf_arm_reg <= 1'b0;
    end else begin
      // status read arms each clear sequence
      if (rd_a && idx == `SPC_IDX_STATUS) begin
        tc_arm_reg <= tc_reg;
        te_arm_reg <= te_reg;
        mf_arm_reg <= mf_reg;
      end
      if (rd_a && idx == `SPC_IDX_DATA && tc_arm_reg) begin
        tc_reg     <= 1'b0;
        tc_arm_reg <= 1'b0;
      end
      if (wr_a && idx == `SPC_IDX_CTRL1 && mf_arm_reg) begin
        mf_reg     <= 1'b0;
        mf_arm_reg <= 1'b0;
      end
      // an unarmed data write is dropped
      if (d_ok) begin
        txb_reg    <= wd;
        txf_reg    <= 1'b1;
        te_reg     <= 1'b0;
        te_arm_reg <= 1'b0;
      end
      if (load) begin
        txf_reg <= 1'b0;
        te_reg  <= 1'b1;
      end
      // an unread byte is kept; later bytes are lost
      if (last) begin
        tc_reg <= 1'b1;
        if (!tc_reg)
          rx_reg <= sh_nx;
      end
      // flag survives a later clear of the enable
      if (mfault)
        mf_reg <= 1'b1;
    end
  end

  // ***************************************************************
  // pin drivers and interrupt
  // ***************************************************************

  reg n_mosi_oe;
  reg n_miso_oe;
  wire dout = obit(sh_reg, lsbf);

  // output enables by role and pin mode
  always @* begin
    n_mosi_oe = 1'b0;
    n_miso_oe = 1'b0;
    if (en && role_select && !mf_reg) begin
      n_mosi_oe = pin1 ? bioe : 1'b1;
    end else if (en && !role_select && !ss_f_reg) begin
      n_miso_oe = pin1 ? bioe : 1'b1;
    end
  end

  // all pin outputs leave from flops
  always @(posedge clock) begin
    if (!reset_n) begin
      mosi_out <= 1'b0;
      mosi_oe  <= 1'b0;
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
      sck_out  <= 1'b0;
      sck_oe   <= 1'b0;
      ss_out   <= 1'b1;
      ss_oe    <= 1'b0;
      irq      <= 1'b0;
    end else begin
      mosi_out <= dout;
      mosi_oe  <= n_mosi_oe;
      miso_out <= dout;
      miso_oe  <= n_miso_oe;
      sck_out  <= pol ^ lvl_reg;
      sck_oe   <= en & role_select & ~mf_reg;
      ss_out   <= ~busy_reg;
      ss_oe    <= en & role_select & mfe & select_output_enable;
      irq      <= (ie & (tc_reg | mf_reg))
                  | (tie & te_reg);
    end
  end

endmodule // spc_core
`default_nettype wire

// ===== sim/spc_core_assertions.sv
// concurrent checks on the serial port core's bus answer and pin enables
`timescale 1ns/10ps
`default_nettype none
module spc_core_assertions (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        mosi_oe,
  input wire logic        miso_oe,
  input wire logic        sck_oe,
  input wire logic        ss_oe,
  input wire logic        irq
);
  logic [7:0] c1_reg, c1_q, c1_qq;
  wire  [2:0] idx    = avs_address[4:2];
  wire  [7:0] c1_any = c1_reg | c1_q | c1_qq;
  wire  [7:0] c1_all = c1_reg & c1_q & c1_qq;
  wire        rd_now = avs_read && !avs_waitrequest;
  // ****************************************
  // shadow of control one
  // ****************************************
  // pins lag the register by up to two flops, so keep two older copies
  always @(posedge clock) begin
    if (!reset_n) begin
      c1_reg <= 8'h04;
      c1_q   <= 8'h04;
      c1_qq  <= 8'h04;
    end else begin
      if (avs_write && !avs_waitrequest && avs_byteenable[0] && idx == 3'h0)
        c1_reg <= avs_writedata[7:0];
      c1_q  <= c1_reg;
      c1_qq <= c1_q;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low two cycles running");
  wait_prompt_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  ctrl_read_a: assert property (
    rd_now && idx == 3'h0 |-> avs_readdata[7:0] == c1_reg)
    else $error("control one read back differs from last write");
  rsvd_zero_a: assert property (
    rd_now && (idx == 3'h4 || idx > 3'h5) |-> avs_readdata == 32'h0)
    else $error("reserved location read not zero");
  pins_off_a: assert property (
    !c1_any[6] |-> !(sck_oe || mosi_oe || miso_oe || ss_oe))
    else $error("pin driven while port disabled");
  slave_pins_a: assert property (!c1_any[4] |-> !sck_oe && !mosi_oe)
    else $error("slave drives clock or master data pin");
  master_miso_a: assert property (c1_all[4] |-> !miso_oe)
    else $error("master drives slave data pin");
  irq_quiet_a: assert property (!c1_any[7] && !c1_any[5] |-> !irq)
    else $error("interrupt with both enables clear");
  ss_drive_a: assert property (
    ss_oe |-> c1_any[6] && c1_any[4] && c1_any[1])
    else $error("select driven outside enabled master");
endmodule  // spc_core_assertions
bind spc_core spc_core_assertions chk (.clock, .reset_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .mosi_oe, .miso_oe, .sck_oe, .ss_oe, .irq);
`default_nettype wire

// ===== sim/spc_peer.sv
// behavioural far-end slave on the serial pins, phase zero, idle-low clock
`timescale 1ns/10ps
`default_nettype none
module spc_peer (
  input  wire logic       sck,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh_reg;
  // a new frame loads the reply byte
  always @(negedge sel_n) sh_reg = tx_byte;
  // rising edge samples, falling edge shifts, as the port's polarity
  always @(sck) begin
    if (!sel_n && sck === 1'b1)
      rx_byte = {rx_byte[6:0], mosi};
    else if (!sel_n)
      sh_reg = {sh_reg[6:0], 1'b0};
  end
  // deselected line shows the inverse so a stale bit never passes
  assign miso = sel_n ? ~sh_reg[7] : sh_reg[7];
endmodule  // spc_peer
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the serial port core
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, w) begin samples_checked++; if ((g) !== (w)) begin \
  n_mismatch++; $display("wrong value at %0t: got %h want %h", \
  $time, g, w); end end
module tb_top;
  logic        clock = 0, reset_n = 0, link_clk = 0, link_on = 0;
  logic [4:0]  avs_address = 0;
  logic        avs_read = 0, avs_write = 0;
  logic [31:0] avs_writedata = 0, avs_readdata;
  logic [3:0]  avs_byteenable = 4'h1;
  logic        avs_waitrequest, irq, wait_mode = 0, stop_mode = 0;
  logic        mosi_out, mosi_oe, miso_out, miso_oe, peer_miso;
  logic        sck_out, sck_oe, ss_out, ss_oe, tb_ss = 1, tb_mosi = 0;
  logic [7:0]  peer_tx = 0, peer_rx;
  int          n_mismatch = 0, samples_checked = 0;
  // every pin level resolved from all drivers
  wire ss_pin   = ss_oe ? ss_out : tb_ss;
  wire sck_pin  = sck_oe ? sck_out : (link_on & link_clk);
  wire mosi_pin = mosi_oe ? mosi_out : tb_mosi;
  wire miso_pin = miso_oe ? miso_out : peer_miso;
  always #5 clock = ~clock;
  always #62.5 link_clk = ~link_clk;
  spc_core uut (.clock, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .wait_mode, .stop_mode, .mosi_in(mosi_pin), .mosi_out, .mosi_oe,
    .miso_in(miso_pin), .miso_out, .miso_oe, .sck_in(sck_pin), .sck_out,
    .sck_oe, .ss_in(ss_pin), .ss_out, .ss_oe, .irq);
  spc_peer peer (.sck(sck_pin), .sel_n(ss_pin), .mosi(mosi_pin),
    .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx));
  // ****************************************
  // bus tasks
  // ****************************************
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [2:0] i,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clock);
    avs_address <= {i, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    n = 0;
    do begin @(posedge clock); n++; end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      give_verdict;
    end
    q = avs_readdata[7:0];
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1, i, d, q);
  endtask
  task automatic rd_chk(input logic [2:0] i, input logic [7:0] w);
    logic [7:0] q;
    bus(0, i, 8'h00, q);
    `CHK(q, w)
  endtask
  // polls status; a bounded poll that runs out counts as a mismatch
  task automatic wait_tc;
    logic [7:0] s;
    int n;
    s = 0;
    for (n = 0; n < 100 && !s[7]; n++) bus(0, 3'h3, 8'h00, s);
    if (!s[7]) begin
      n_mismatch++;
      give_verdict;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic check_regs;
    logic [7:0] rv [8] = '{8'h04, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00,
                           8'h00, 8'h00};
    logic [7:0] mv [4] = '{8'h1b, 8'h77, 8'h20, 8'h00};
    wr(3'h5, 8'h11);  // no status read first, so ignored
    for (int i = 0; i < 8; i++) rd_chk(i[2:0], rv[i]);
    for (int i = 1; i < 5; i++) wr(i[2:0], 8'hff);
    for (int i = 1; i < 5; i++) rd_chk(i[2:0], mv[i-1]);
  endtask
  task automatic mxfer(input logic [7:0] c1, tx, ptx, wp, wr_d);
    peer_tx = ptx;
    wr(3'h0, c1);
    rd_chk(3'h3, 8'h20);
    wr(3'h5, tx);
    wait_tc;
    `CHK(irq, c1[7] | c1[5])
    rd_chk(3'h5, wr_d);
    `CHK(peer_rx, wp)
    rd_chk(3'h3, 8'h20);
    `CHK(irq, c1[5])
  endtask
  task automatic check_irq_fault;
    wr(3'h0, 8'h72);
    rd_chk(3'h3, 8'h20);
    `CHK(irq, 1'b1)
    wr(3'h0, 8'h50);
    tb_ss <= 0;
    repeat (10) @(posedge clock);
    tb_ss <= 1;
    rd_chk(3'h3, 8'h30);
    `CHK(irq, 1'b0)
    wr(3'h1, 8'h00);
    rd_chk(3'h3, 8'h30);
    wr(3'h0, 8'h58);
    rd_chk(3'h3, 8'h20);
    `CHK({sck_oe, sck_out}, 2'b11)
  endtask
  // bidir master data pin, then wait with stop-in-wait freezing a byte
  task automatic wait_freeze;
    logic [7:0] s;
    wr(3'h1, 8'h01);
    repeat (2) @(posedge clock);
    `CHK(mosi_oe, 1'b0)
    wr(3'h1, 8'h0b);
    repeat (2) @(posedge clock);
    `CHK(mosi_oe, 1'b1)
    wr(3'h1, 8'h02);
    wr(3'h0, 8'h50);
    wait_mode <= 1;
    rd_chk(3'h3, 8'h20);
    wr(3'h5, 8'h3c);
    repeat (200) @(posedge clock);
    bus(0, 3'h3, 8'h00, s);
    `CHK(s[7], 1'b0)
    wait_mode <= 0;
    wait_tc;
    bus(0, 3'h5, 8'h00, s);
  endtask
  // slave byte on the link clock while the cpu sits in stop and wait
  task automatic slave_xfer;
    logic [7:0] m, r;
    wr(3'h0, 8'h40);
    rd_chk(3'h3, 8'h20);
    wr(3'h5, 8'h5a);
    m = 8'h96;
    r = 0;
    stop_mode <= 1;
    wait_mode <= 1;
    tb_ss <= 0;
    tb_mosi <= m[7];
    repeat (8) @(posedge clock);
    @(negedge link_clk) link_on = 1;
    for (int i = 0; i < 8; i++) begin
      @(posedge link_clk) r = {r[6:0], miso_pin};
      @(negedge link_clk) m = m << 1;
      tb_mosi = m[7];
    end
    link_on = 0;
    repeat (20) @(posedge clock);
    tb_ss <= 1;
    stop_mode <= 0;
    wait_mode <= 0;
    wait_tc;
    rd_chk(3'h5, 8'h96);
    `CHK(r, 8'h5a)
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // main sequence; divider 16 keeps the pin synchronisers ahead of edges
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1;
    check_regs;
    wr(3'h1, 8'h10);
    wr(3'h2, 8'h03);
    mxfer(8'hd2, 8'ha5, 8'h3c, 8'ha5, 8'h3c);
    mxfer(8'h53, 8'h01, 8'hc0, 8'h80, 8'h03);
    check_irq_fault;
    wait_freeze;
    slave_xfer;
    give_verdict;
  end
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    give_verdict;
  end
endmodule  // tb_top
`default_nettype wire
